/* rtl/qpt_pkg.sv */
// constants, field layouts and mode codes for the quad prescaled timer
// assumes one system clock; timer clock arrives as a sampled input
package qpt_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_A_CTL = 4'h0;
  localparam logic [3:0] ADDR_B_CTL = 4'h1;
  localparam logic [3:0] ADDR_CD_CTL = 4'h2;
  localparam logic [3:0] ADDR_A_DATA = 4'h3;
  localparam logic [3:0] ADDR_B_DATA = 4'h4;
  localparam logic [3:0] ADDR_C_DATA = 4'h5;
  localparam logic [3:0] ADDR_D_DATA = 4'h6;
  localparam logic [3:0] ADDR_EDGE = 4'h7;
  localparam logic [3:0] ADDR_IEH = 4'h8;
  localparam logic [3:0] ADDR_IEL = 4'h9;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam logic [3:0] CTL_EVENT = 4'h8;
  localparam logic [2:0] PRE_OFF = 3'h0;
  localparam int CTL_OUT_RST_BIT = 4;
  localparam int CD_C_LSB = 4;
  localparam int CD_D_LSB = 0;
  localparam int EDGE_A_BIT = 4;
  localparam int EDGE_B_BIT = 3;
  localparam int IEH_TA_BIT = 5;
  localparam int IEH_TB_BIT = 0;
  localparam int IEL_P4_BIT = 6;
  localparam int IEL_TC_BIT = 5;
  localparam int IEL_TD_BIT = 4;
  localparam int IEL_P3_BIT = 3;
  localparam logic [7:0] PRE_DIV [8] = '{8'h01, 8'h04, 8'h0A, 8'h10, 8'h32, 8'h40, 8'h64, 8'hC8};

  typedef enum logic [1:0] {
    QPT_STOP = 2'b00,
    QPT_DELAY = 2'b01,
    QPT_PULSE = 2'b10,
    QPT_EVENT = 2'b11
  } qpt_mode_t;

  // prescale select to divide ratio
  function automatic logic [7:0] qpt_div(input logic [2:0] sel);
    return PRE_DIV[sel];
  endfunction

  // low nibble of an A/B control register to mode
  function automatic qpt_mode_t qpt_ctl_mode(input logic [3:0] code);
    if (code == CTL_EVENT) begin
      return QPT_EVENT;
    end
    if (code[2:0] == PRE_OFF) begin
      return QPT_STOP;
    end
    return code[3] ? QPT_PULSE : QPT_DELAY;
  endfunction

  // level seen by a transition detector
  function automatic logic qpt_active(input logic lvl, input logic edge_bit, input logic inv);
    return lvl ^ ~edge_bit ^ inv;
  endfunction
endpackage

/* rtl/qpt_tmr_if.sv */
// control and status bundle between the register side and one timer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface qpt_tmr_if;
  import qpt_pkg::*;
  qpt_mode_t mode;
  logic [2:0] presc;
  logic tick;
  logic gate;
  logic event_pulse;
  logic load_wr;
  logic [7:0] load_data;
  logic out_rst;
  logic [7:0] count;
  logic timeout;
  logic wave;
  modport ctl (output mode, presc, tick, gate, event_pulse, load_wr, load_data, out_rst,
    input count, timeout, wave);
  modport tmr (input mode, presc, tick, gate, event_pulse, load_wr, load_data, out_rst,
    output count, timeout, wave);
endinterface

/* rtl/qpt_timer.sv */
// one prescaler and 8-bit down counter with toggling output
// assumes tick is a one-cycle pulse per timer clock edge
`timescale 1ns/1ps
module qpt_timer (
  input wire logic clk_in,
  input wire logic reset_n_in,
  qpt_tmr_if.tmr bus
);
  import qpt_pkg::*;

  typedef struct packed {
    logic [7:0] pre;
    logic [2:0] sel;
    logic [7:0] count;
    logic [7:0] reload;
    logic timeout;
    logic wave;
  } qpt_tmr_state_t;

  qpt_tmr_state_t st_ff;
  qpt_tmr_state_t nxt_st;
  logic cp;
  logic run;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.timeout = 1'b0;
    nxt_st.sel = bus.presc;
    run = bus.tick && (bus.mode == QPT_DELAY || (bus.mode == QPT_PULSE && bus.gate));
    cp = 1'b0;
    if (bus.mode == QPT_EVENT) begin
      cp = bus.event_pulse;
      nxt_st.pre = PRE_ZERO;
    end else if (bus.presc != st_ff.sel) begin
      nxt_st.pre = PRE_ZERO;
    end else if (run) begin
      if (st_ff.pre + CNT_STEP >= qpt_div(bus.presc)) begin
        nxt_st.pre = PRE_ZERO;
        cp = 1'b1;
      end else begin
        nxt_st.pre = st_ff.pre + CNT_STEP;
      end
    end
    if (cp) begin
      if (st_ff.count == CNT_ONE) begin
        nxt_st.count = st_ff.reload;
        nxt_st.timeout = 1'b1;
        nxt_st.wave = ~st_ff.wave;
      end else begin
        nxt_st.count = st_ff.count - CNT_STEP;
      end
    end
    if (bus.load_wr) begin
      nxt_st.reload = bus.load_data;
      if (bus.mode == QPT_STOP) begin
        nxt_st.count = bus.load_data;
      end
    end
    if (bus.out_rst) begin
      nxt_st.wave = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.count = st_ff.count;
  assign bus.timeout = st_ff.timeout;
  assign bus.wave = st_ff.wave;

  reload_at_one_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cp && st_ff.count == CNT_ONE && !bus.load_wr) |=>
    (st_ff.timeout && st_ff.count == $past(st_ff.reload)))
    else $error("counter did not reload at one");
  count_step_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cp && st_ff.count != CNT_ONE && !(bus.load_wr && bus.mode == QPT_STOP)) |=>
    (st_ff.count == $past(st_ff.count) - CNT_STEP))
    else $error("counter did not step down");
  wave_toggle_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!bus.out_rst && !$past(bus.out_rst)) |-> (st_ff.timeout == (st_ff.wave != $past(st_ff.wave))))
    else $error("output changed without a time-out");
  gate_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bus.mode == QPT_PULSE && !bus.gate && !bus.load_wr) |=> $stable(st_ff.count))
    else $error("counter moved while gate inactive");
  stop_load_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bus.load_wr && bus.mode == QPT_STOP) |=> (st_ff.count == $past(bus.load_data)))
    else $error("stopped write did not load counter");
  timeout_len_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (st_ff.timeout && bus.mode != QPT_EVENT) |=> !st_ff.timeout)
    else $error("time-out longer than one cycle");
endmodule

/* rtl/qpt_top.sv */
// quad prescaled timer: registers, auxiliary inputs, interrupt channel requests
// assumes all inputs synchronous to clk_in; timer clock sampled on timer_osc_in
// Overview of operation
// - four 8-bit prescaler plus down-counter timers on one shared timer clock
// - each time-out toggles the timer output, which holds until next time-out
// - A and B: delay, pulse width, event count; C and D delay only
// - delay mode: prescaler runs, emits count pulse decrementing the counter
// - count pulse at 01 reloads counter from data and produces time-out
// - time-out requests an interrupt only when its channel is enabled
// - prescale change: first count pulse within 1 to 200 timer clocks
// - reload 01 times out every pulse; 00 every 256 pulses
// - pulse mode moves port 4/3 channels onto aux inputs A/B
// - pulse mode: aux input at active level gates prescaler and counter
// - edge bit 4 (A) / 3 (B) sets aux active level, one is high
// - pulse mode interrupt fires on the opposite edge, ending the pulse
// - pulse mode rewrite keeps counting old value until reload at 01
// - leaving pulse mode restores polarity; mode or edge change may interrupt
// - event mode count through 01 times out, toggles, interrupts, reloads
// - event mode edge bit one counts rising, zero falling; change may count
// - event mode aux edges also request the port 3/4 channel when enabled
// - three control registers and four data registers, C and D share control
// - data write loads counter too when stopped, else at next pass of 01
// - control selects mode, prescale, stop; A and B can force output low
// - data read returns the counter captured at the read strobe
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module qpt_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [qpt_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic timer_osc_in,
  input wire logic timer_a_aux_input_in,
  input wire logic timer_b_aux_input_in,
  input wire logic port_pin_3_in,
  input wire logic port_pin_4_in,
  output logic timer_a_out,
  output logic timer_b_out,
  output logic timer_c_out,
  output logic timer_d_out,
  output logic [3:0] irq_timer_out,
  output logic irq_port_line_3_out,
  output logic irq_port_line_4_out
);
  import qpt_pkg::*;

  typedef struct packed {
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] ctl_cd;
    logic [7:0] edge_sel;
    logic [7:0] ien_hi;
    logic [7:0] ien_lo;
    logic osc_q;
    logic osc_prev;
    logic aux_a_q;
    logic aux_b_q;
    logic p3_q;
    logic p4_q;
    logic ev_a;
    logic ev_b;
    logic det3;
    logic det4;
    logic [7:0] rdata;
    logic [3:0] irq_t;
    logic irq3;
    logic irq4;
  } qpt_top_state_t;

  qpt_top_state_t st_ff;
  qpt_top_state_t nxt_st;

  qpt_tmr_if tif [4] ();

  qpt_mode_t mode_w [4];
  logic [2:0] presc_w [4];
  logic gate_w [4];
  logic ev_w [4];
  logic load_w [4];
  logic orst_w [4];
  logic [7:0] cnt_w [4];
  logic to_w [4];
  logic wave_w [4];
  logic tick;
  logic act_a;
  logic act_b;
  logic sig3;
  logic sig4;
  logic aux_a_mode;
  logic aux_b_mode;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tmr
      assign tif[gi].mode = mode_w[gi];
      assign tif[gi].presc = presc_w[gi];
      assign tif[gi].tick = tick;
      assign tif[gi].gate = gate_w[gi];
      assign tif[gi].event_pulse = ev_w[gi];
      assign tif[gi].load_wr = load_w[gi];
      assign tif[gi].load_data = wdata_in;
      assign tif[gi].out_rst = orst_w[gi];
      assign cnt_w[gi] = tif[gi].count;
      assign to_w[gi] = tif[gi].timeout;
      assign wave_w[gi] = tif[gi].wave;
      qpt_timer i_qpt_timer (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .bus(tif[gi])
      );
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    // sampled pins
    nxt_st.osc_q = timer_osc_in;
    nxt_st.osc_prev = st_ff.osc_q;
    nxt_st.aux_a_q = timer_a_aux_input_in;
    nxt_st.aux_b_q = timer_b_aux_input_in;
    nxt_st.p3_q = port_pin_3_in;
    nxt_st.p4_q = port_pin_4_in;
    tick = st_ff.osc_q && !st_ff.osc_prev;
    // A/B full modes, C/D delay only
    mode_w[0] = qpt_ctl_mode(st_ff.ctl_a[3:0]);
    mode_w[1] = qpt_ctl_mode(st_ff.ctl_b[3:0]);
    mode_w[2] = (st_ff.ctl_cd[CD_C_LSB+:3] == PRE_OFF) ? QPT_STOP : QPT_DELAY;
    mode_w[3] = (st_ff.ctl_cd[CD_D_LSB+:3] == PRE_OFF) ? QPT_STOP : QPT_DELAY;
    presc_w[0] = st_ff.ctl_a[2:0];
    presc_w[1] = st_ff.ctl_b[2:0];
    presc_w[2] = st_ff.ctl_cd[CD_C_LSB+:3];
    presc_w[3] = st_ff.ctl_cd[CD_D_LSB+:3];
    // forced output reset on A and B
    orst_w[0] = st_ff.ctl_a[CTL_OUT_RST_BIT];
    orst_w[1] = st_ff.ctl_b[CTL_OUT_RST_BIT];
    orst_w[2] = 1'b0;
    orst_w[3] = 1'b0;
    // aux active level from edge bit
    gate_w[0] = (st_ff.aux_a_q == st_ff.edge_sel[EDGE_A_BIT]);
    gate_w[1] = (st_ff.aux_b_q == st_ff.edge_sel[EDGE_B_BIT]);
    gate_w[2] = 1'b0;
    gate_w[3] = 1'b0;
    act_a = qpt_active(st_ff.aux_a_q, st_ff.edge_sel[EDGE_A_BIT], 1'b0);
    act_b = qpt_active(st_ff.aux_b_q, st_ff.edge_sel[EDGE_B_BIT], 1'b0);
    nxt_st.ev_a = act_a;
    nxt_st.ev_b = act_b;
    ev_w[0] = act_a && !st_ff.ev_a;
    ev_w[1] = act_b && !st_ff.ev_b;
    ev_w[2] = 1'b0;
    ev_w[3] = 1'b0;
    load_w[0] = wr_in && addr_in == ADDR_A_DATA;
    load_w[1] = wr_in && addr_in == ADDR_B_DATA;
    load_w[2] = wr_in && addr_in == ADDR_C_DATA;
    load_w[3] = wr_in && addr_in == ADDR_D_DATA;
    // channels follow aux inputs in aux modes
    aux_a_mode = mode_w[0] == QPT_PULSE || mode_w[0] == QPT_EVENT;
    aux_b_mode = mode_w[1] == QPT_PULSE || mode_w[1] == QPT_EVENT;
    sig4 = qpt_active(aux_a_mode ? st_ff.aux_a_q : st_ff.p4_q,
      st_ff.edge_sel[EDGE_A_BIT], mode_w[0] == QPT_PULSE);
    sig3 = qpt_active(aux_b_mode ? st_ff.aux_b_q : st_ff.p3_q,
      st_ff.edge_sel[EDGE_B_BIT], mode_w[1] == QPT_PULSE);
    // detector sees mode and edge changes
    nxt_st.det4 = sig4;
    nxt_st.det3 = sig3;
    nxt_st.irq4 = sig4 && !st_ff.det4 && st_ff.ien_lo[IEL_P4_BIT];
    nxt_st.irq3 = sig3 && !st_ff.det3 && st_ff.ien_lo[IEL_P3_BIT];
    nxt_st.irq_t[0] = to_w[0] && st_ff.ien_hi[IEH_TA_BIT];
    nxt_st.irq_t[1] = to_w[1] && st_ff.ien_hi[IEH_TB_BIT];
    nxt_st.irq_t[2] = to_w[2] && st_ff.ien_lo[IEL_TC_BIT];
    nxt_st.irq_t[3] = to_w[3] && st_ff.ien_lo[IEL_TD_BIT];
    if (wr_in) begin
      case (addr_in)
        ADDR_A_CTL: begin
          nxt_st.ctl_a = wdata_in;
        end
        ADDR_B_CTL: begin
          nxt_st.ctl_b = wdata_in;
        end
        ADDR_CD_CTL: begin
          nxt_st.ctl_cd = wdata_in;
        end
        ADDR_EDGE: begin
          nxt_st.edge_sel = wdata_in;
        end
        ADDR_IEH: begin
          nxt_st.ien_hi = wdata_in;
        end
        ADDR_IEL: begin
          nxt_st.ien_lo = wdata_in;
        end
        default: begin
          nxt_st.ien_lo = st_ff.ien_lo;
        end
      endcase
    end
    nxt_st.rdata = REG_RST;
    if (rd_in) begin
      case (addr_in)
        ADDR_A_CTL: begin
          nxt_st.rdata = st_ff.ctl_a;
        end
        ADDR_B_CTL: begin
          nxt_st.rdata = st_ff.ctl_b;
        end
        ADDR_CD_CTL: begin
          nxt_st.rdata = st_ff.ctl_cd;
        end
        ADDR_A_DATA: begin
          nxt_st.rdata = cnt_w[0];
        end
        ADDR_B_DATA: begin
          nxt_st.rdata = cnt_w[1];
        end
        ADDR_C_DATA: begin
          nxt_st.rdata = cnt_w[2];
        end
        ADDR_D_DATA: begin
          nxt_st.rdata = cnt_w[3];
        end
        ADDR_EDGE: begin
          nxt_st.rdata = st_ff.edge_sel;
        end
        ADDR_IEH: begin
          nxt_st.rdata = st_ff.ien_hi;
        end
        ADDR_IEL: begin
          nxt_st.rdata = st_ff.ien_lo;
        end
        default: begin
          nxt_st.rdata = REG_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
      // detectors start at idle level
      st_ff.ev_a <= 1'b1;
      st_ff.ev_b <= 1'b1;
      st_ff.det3 <= 1'b1;
      st_ff.det4 <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out = st_ff.rdata;
  assign timer_a_out = wave_w[0];
  assign timer_b_out = wave_w[1];
  assign timer_c_out = wave_w[2];
  assign timer_d_out = wave_w[3];
  assign irq_timer_out = st_ff.irq_t;
  assign irq_port_line_3_out = st_ff.irq3;
  assign irq_port_line_4_out = st_ff.irq4;

  irq_gate_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (to_w[0] && !st_ff.ien_hi[IEH_TA_BIT]) |=> !irq_timer_out[0])
    else $error("disabled time-out raised a request");
  irq_follow_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (to_w[2] && st_ff.ien_lo[IEL_TC_BIT]) |=> irq_timer_out[2] ##1 !irq_timer_out[2])
    else $error("time-out request not one cycle");
  read_count_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (rd_in && addr_in == ADDR_B_DATA) |=> (rdata_out == $past(cnt_w[1])))
    else $error("data read not counter snapshot");
  pulse_irq_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_w[1] == QPT_PULSE && $stable(mode_w[1]) && $stable(st_ff.edge_sel)
      && st_ff.ien_lo[IEL_P3_BIT] && $fell(gate_w[1])) |=> irq_port_line_3_out)
    else $error("pulse end did not request port 3 channel");

  irq_a_pass_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (to_w[0] && st_ff.ien_hi[IEH_TA_BIT]) |=> irq_timer_out[0])
    else $error("enabled time-out gave no request");

  irq_b_match_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    irq_timer_out[1] == $past(to_w[1] && st_ff.ien_hi[IEH_TB_BIT]))
    else $error("timer b request does not follow time-out");

  irq_d_match_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    irq_timer_out[3] == $past(to_w[3] && st_ff.ien_lo[IEL_TD_BIT]))
    else $error("timer d request does not follow time-out");

  port3_gate_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !st_ff.ien_lo[IEL_P3_BIT] |=> !irq_port_line_3_out)
    else $error("disabled port 3 channel raised a request");

  port4_gate_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !st_ff.ien_lo[IEL_P4_BIT] |=> !irq_port_line_4_out)
    else $error("disabled port 4 channel raised a request");

  event_step_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_w[0] == QPT_EVENT && ev_w[0] && cnt_w[0] != CNT_ONE) |=>
    (cnt_w[0] == $past(cnt_w[0]) - CNT_STEP))
    else $error("event did not step counter down");

  event_idle_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_w[0] == QPT_EVENT && !ev_w[0]) |=> $stable(cnt_w[0]))
    else $error("event counter moved without an event");

  event_reload_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_w[1] == QPT_EVENT && ev_w[1] && cnt_w[1] == CNT_ONE && !orst_w[1]) |=>
    (to_w[1] && timer_b_out != $past(timer_b_out)))
    else $error("event count through one gave no time-out");

  active_high_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_w[1] == QPT_PULSE && st_ff.edge_sel[EDGE_B_BIT] && !st_ff.aux_b_q) |=>
    $stable(cnt_w[1]))
    else $error("active high gate counted while low");

  port_mask_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_w[1] == QPT_EVENT && $stable(mode_w[1]) && $stable(st_ff.aux_b_q)
      && $stable(st_ff.edge_sel)) |=> !irq_port_line_3_out)
    else $error("port line reached channel in aux mode");

  event_port_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_w[1] == QPT_EVENT && $stable(mode_w[1]) && $stable(st_ff.edge_sel)
      && st_ff.ien_lo[IEL_P3_BIT] && ev_w[1]) |=> irq_port_line_3_out)
    else $error("aux event did not request port 3 channel");

  force_low_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    orst_w[0] |=> !timer_a_out)
    else $error("forced output not low");

  rdata_idle_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !rd_in |=> (rdata_out == REG_RST))
    else $error("read data outside read cycle");

  ctl_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_in && addr_in == ADDR_CD_CTL) |=> (st_ff.ctl_cd == $past(wdata_in)))
    else $error("shared control write lost");

  edge_read_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (rd_in && addr_in == ADDR_EDGE) |=> (rdata_out == $past(st_ff.edge_sel)))
    else $error("edge register read wrong");
endmodule

/* dv/qpt_aux_src.sv */
// behavioural source for the two auxiliary timer inputs
// assumes one timer clock every TICK_CLK system clocks
`timescale 1ns/1ps
module qpt_aux_src #(
  parameter int TICK_CLK = 4
) (
  input wire logic clk_in,
  output logic aux_a_out,
  output logic aux_b_out
);
  initial begin
    aux_a_out = 1'b0;
    aux_b_out = 1'b0;
  end

  // edges at least four timer clocks apart
  task automatic pulse(input int ch, input int hi_t, input int lo_t);
    int hi;
    int lo;
    hi = (hi_t < 4) ? 4 : hi_t;
    lo = (lo_t < 4) ? 4 : lo_t;
    @(posedge clk_in);
    if (ch == 0) begin
      aux_a_out <= 1'b1;
    end else begin
      aux_b_out <= 1'b1;
    end
    repeat (hi * TICK_CLK) @(posedge clk_in);
    if (ch == 0) begin
      aux_a_out <= 1'b0;
    end else begin
      aux_b_out <= 1'b0;
    end
    repeat (lo * TICK_CLK - 1) @(posedge clk_in);
  endtask
endmodule

/* dv/qpt_tb.sv */
// self-checking bench for the quad prescaled timer with a count model
// assumes qpt_aux_src drives the auxiliary inputs; timer clock is clk_in / 4
`timescale 1ns/1ps
module qpt_top_tb;
  import qpt_pkg::*;
  localparam int NT = 2062;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic osc = 1'b0;
  logic [1:0] ph = 2'h0;
  logic pin3 = 1'b0;
  logic pin4 = 1'b0;
  logic aux_a;
  logic aux_b;
  logic [3:0] outs;
  logic [3:0] outs_q = 4'h0;
  logic [3:0] irq;
  logic p3;
  logic p4;
  int irq_n[4];
  int tog_n[4];
  int p3_n = 0;
  int p4_n = 0;
  int num_errors = 0;
  int check_count = 0;
  int seed = 32'h8C32;
  int dv[4] = '{4, 4, 10, 4};
  int rl[4] = '{1, 2, 3, 0};
  int en[4] = '{1, 0, 1, 0};
  int e;
  logic [3:0] a;
  logic [7:0] v;
  logic [7:0] sv;
  logic [7:0] q[$];

  always #2.5 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    ph <= ph + 2'h1;
    osc <= ph[1];
  end

  qpt_top i_qpt_top (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .timer_osc_in(osc),
    .timer_a_aux_input_in(aux_a), .timer_b_aux_input_in(aux_b),
    .port_pin_3_in(pin3), .port_pin_4_in(pin4), .timer_a_out(outs[0]),
    .timer_b_out(outs[1]), .timer_c_out(outs[2]), .timer_d_out(outs[3]),
    .irq_timer_out(irq), .irq_port_line_3_out(p3), .irq_port_line_4_out(p4)
  );

  qpt_aux_src i_qpt_aux_src (.clk_in(clk_in), .aux_a_out(aux_a), .aux_b_out(aux_b));

  // event counters seen at the pins
  always @(negedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      irq_n[i] += (irq[i] === 1'b1);
      tog_n[i] += (outs[i] !== outs_q[i]);
    end
    p3_n += (p3 === 1'b1);
    p4_n += (p4 === 1'b1);
    outs_q = outs;
  end

  function automatic int n_to(input int ticks, input int div, input int rld);
    return ticks / (div * ((rld == 0) ? 256 : rld));
  endfunction

  task automatic clr();
    for (int i = 0; i < 4; i++) begin
      irq_n[i] = 0;
      tog_n[i] = 0;
    end
    p3_n = 0;
    p4_n = 0;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk_in);
    addr <= ad;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad);
    @(posedge clk_in);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    @(negedge clk_in);
    v = rdata;
  endtask

  task automatic pins(input int n);
    repeat (n) begin
      @(posedge clk_in);
      pin3 <= 1'b1;
      pin4 <= 1'b1;
      repeat (8) @(posedge clk_in);
      pin3 <= 1'b0;
      pin4 <= 1'b0;
      repeat (8) @(posedge clk_in);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    $display("mismatch watchdog expected done seen hang");
    summarize();
  end

  initial begin
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0]);
      check("reset read", 8'h00, v);
    end
    repeat (3) begin
      a = 4'hA + 4'($unsigned($random(seed)) % 6);
      wr(a, 8'($random(seed)));
      rd(a);
      check("unmapped read", 8'h00, v);
    end
    for (int t = 0; t < 4; t++) begin
      q.push_back(8'($random(seed)));
      wr(ADDR_A_DATA + t[3:0], q[t]);
    end
    for (int t = 0; t < 4; t++) begin
      rd(ADDR_A_DATA + t[3:0]);
      check("stopped load", q.pop_front(), v);
    end
    // delay mode on all four timers
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_A_DATA + t[3:0], 8'(rl[t]));
    end
    wr(ADDR_IEH, 8'h20);
    wr(ADDR_IEL, 8'h20);
    clr();
    wr(ADDR_A_CTL, 8'h01);
    wr(ADDR_B_CTL, 8'h01);
    wr(ADDR_CD_CTL, 8'h21);
    repeat (NT * 4) @(posedge clk_in);
    wr(ADDR_A_CTL, 8'h00);
    wr(ADDR_B_CTL, 8'h00);
    wr(ADDR_CD_CTL, 8'h00);
    repeat (8) @(posedge clk_in);
    for (int t = 0; t < 4; t++) begin
      e = n_to(NT, dv[t], rl[t]);
      check("toggles", e, tog_n[t]);
      check("timeouts", (en[t] != 0) ? e : 0, irq_n[t]);
    end
    check("out a level", n_to(NT, 4, 1) % 2, outs[0]);
    wr(ADDR_A_CTL, 8'h10);
    repeat (2) @(posedge clk_in);
    check("forced low", 1'b0, outs[0]);
    wr(ADDR_A_CTL, 8'h00);
    // event count: A rising, B falling
    wr(ADDR_A_DATA, 8'h03);
    wr(ADDR_B_DATA, 8'h02);
    wr(ADDR_EDGE, 8'h10);
    wr(ADDR_IEH, 8'h21);
    wr(ADDR_IEL, 8'h48);
    clr();
    pins(2);
    wr(ADDR_A_CTL, 8'h08);
    wr(ADDR_B_CTL, 8'h08);
    fork
      repeat (7) i_qpt_aux_src.pulse(0, 4, 4);
      repeat (7) i_qpt_aux_src.pulse(1, 4, 4);
      pins(3);
    join
    repeat (20) @(posedge clk_in);
    check("event a timeouts", 2, irq_n[0]);
    check("event b timeouts", 3, irq_n[1]);
    check("event a toggles", 2, tog_n[0]);
    check("port4 requests", 9, p4_n);
    check("port3 requests", 9, p3_n);
    rd(ADDR_A_DATA);
    check("event a count", 8'h02, v);
    rd(ADDR_B_DATA);
    check("event b count", 8'h01, v);
    wr(ADDR_A_CTL, 8'h00);
    wr(ADDR_B_CTL, 8'h00);
    // pulse width on B, active high
    wr(ADDR_B_DATA, 8'h20);
    wr(ADDR_EDGE, 8'h18);
    wr(ADDR_IEL, 8'h40);
    wr(ADDR_B_CTL, 8'h09);
    wr(ADDR_IEL, 8'h48);
    clr();
    i_qpt_aux_src.pulse(1, 40, 4);
    rd(ADDR_B_DATA);
    check("pulse width", 1, (v >= 8'h15 && v <= 8'h17));
    sv = v;
    repeat (100) @(posedge clk_in);
    rd(ADDR_B_DATA);
    check("gated hold", sv, v);
    check("pulse end request", 1, p3_n);
    check("no b timeout", 0, irq_n[1]);
    wr(ADDR_B_DATA, 8'h05);
    rd(ADDR_B_DATA);
    check("running write", sv, v);
    summarize();
  end
endmodule
